// *** src/adcsc_top.sv ***
// Summary of operation
// - control write aborts the sequence and restarts it outside trigger mode
// - trigger mode needs one arming write first
// - conversion start equals sampling phase start
// - bit 7 selects result justification
// - bit 6 selects unsigned or two's complement
// - no signed form when right justified
// - bit 5 selects single or continuous sequences
// - trigger mode ignores the continuous bit
// - single channel mode samples the coded channel
// - multi channel increments code, wraps to zero
module adcsc_top
  import adcsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADCSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_trigger,
  input wire logic [ADCSC_RAW_W-1:0] adc_data,
  output logic sample_enable,
  output logic [ADCSC_CODE_W-1:0] channel_select,
  output logic sequence_start,
  output logic result_valid,
  output logic [ADCSC_CODE_W-1:0] result_channel,
  output logic [ADCSC_RES_W-1:0] result_data
);
  logic [7:0] conversion_sequence_control;
  logic [7:0] setup;
  logic bus_ack;
  logic control_write;
  logic setup_write;
  logic trigger_sync;
  logic trigger_last;
  logic trigger_event;
  logic armed;
  logic done;
  adcsc_state_t state;
  logic [5:0] phase_count;
  logic [4:0] conv_left;
  logic [4:0] next_conv_left;
  logic [ADCSC_CODE_W-1:0] chan;
  logic [ADCSC_RES_W-1:0] formatted;
  logic external_trigger_enable;
  logic result_justify_select;
  logic signed_result_select;
  logic continuous_select;
  logic multi_channel_select;
  logic start_now;
  logic busy;

  // ==========================================================
  // helpers
  // code zero selects the longest sequence
  function automatic logic [4:0] seq_len(input logic [7:0] s);
    logic [3:0] code;
    code = s[ADCSC_LEN_LSB +: ADCSC_LEN_W];
    seq_len = (code == 4'h0) ? ADCSC_LEN_FULL : {1'b0, code};
  endfunction

  function automatic logic [ADCSC_CODE_W-1:0] chan_code(
    input logic [7:0] c);
    chan_code = c[ADCSC_CODE_LSB +: ADCSC_CODE_W];
  endfunction

  // ==========================================================
  // field decode
  assign result_justify_select =
    conversion_sequence_control[ADCSC_BIT_JUSTIFY];
  assign signed_result_select =
    conversion_sequence_control[ADCSC_BIT_SIGNED];
  assign continuous_select =
    conversion_sequence_control[ADCSC_BIT_CONTINUOUS];
  assign multi_channel_select =
    conversion_sequence_control[ADCSC_BIT_MULTI];
  assign external_trigger_enable = setup[ADCSC_BIT_TRIG_EN];
  // busy spans both phases so software sees no gap
  assign busy = (state != ADCSC_IDLE);

  // ==========================================================
  // avalon slave: one wait cycle for every access
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign control_write = avs_write & bus_ack
    & (avs_address == ADCSC_ADDR_CONTROL);
  assign setup_write = avs_write & bus_ack
    & (avs_address == ADCSC_ADDR_SETUP);

  // ack toggles so back to back requests each get one wait
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  // captured in the wait cycle so it stands when ack shows
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= ADCSC_UNMAPPED_DATA;
    end else if (avs_read & ~bus_ack) begin
      unique case (avs_address)
        ADCSC_ADDR_CONTROL: begin
          avs_readdata <= {24'h000000, conversion_sequence_control};
        end
        ADCSC_ADDR_SETUP: begin
          avs_readdata <= {24'h000000, setup};
        end
        ADCSC_ADDR_STATUS: begin
          avs_readdata <= {24'h000000, chan, 1'b0, done, armed, busy};
        end
        ADCSC_ADDR_RESULT: begin
          avs_readdata <= {16'h0000, result_data};
        end
        default: begin
          avs_readdata <= ADCSC_UNMAPPED_DATA;
        end
      endcase
    end
  end

  // writable at any time: a write must always abort
  always_ff @(posedge clk) begin
    if (reset) begin
      conversion_sequence_control <= ADCSC_CONTROL_RESET;
    end else if (control_write) begin
      conversion_sequence_control <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      setup <= ADCSC_SETUP_RESET;
    end else if (setup_write) begin
      setup <= avs_writedata[7:0];
    end
  end

  // ==========================================================
  // trigger input
  // pin is asynchronous: two flops before the edge detect
  adcsc_sync u_trig_sync (
    .clk(clk),
    .reset(reset),
    .async_in(external_trigger),
    .sync_out(trigger_sync)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      trigger_last <= 1'b0;
    end else begin
      trigger_last <= trigger_sync;
    end
  end

  // rising edge only: a pin held high starts one sequence
  assign trigger_event = trigger_sync & ~trigger_last;

  // armed by a control write; cleared when trigger mode is left
  always_ff @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (control_write) begin
      armed <= 1'b1;
    end else if (~external_trigger_enable) begin
      armed <= 1'b0;
    end
  end

  // ==========================================================
  // sequence launch
  // a write always wins; in trigger mode it only arms
  // a trigger with no arming write is ignored
  assign start_now = control_write ? ~external_trigger_enable
    : (external_trigger_enable & armed & trigger_event);

  // ==========================================================
  // sequence engine
  // sampling counts down first, then conversion reloads
  assign next_conv_left = conv_left - 5'h01;

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ADCSC_IDLE;
      phase_count <= 6'h00;
      conv_left <= 5'h00;
      chan <= '0;
      done <= 1'b0;
    end else if (control_write & external_trigger_enable) begin
      // abort the running sequence, wait for a trigger
      state <= ADCSC_IDLE;
      done <= 1'b0;
    end else if (start_now & ~control_write & state != ADCSC_IDLE
        & external_trigger_enable) begin
      // trigger during a sequence restarts it
      state <= ADCSC_SAMPLE;
      phase_count <= ADCSC_SAMPLE_CYCLES;
      conv_left <= seq_len(setup);
      chan <= chan_code(conversion_sequence_control);
      done <= 1'b0;
    end else if (start_now) begin
      // written value is used directly for an untriggered start
      state <= ADCSC_SAMPLE;
      phase_count <= ADCSC_SAMPLE_CYCLES;
      conv_left <= seq_len(setup);
      chan <= control_write
        ? chan_code(avs_writedata[7:0])
        : chan_code(conversion_sequence_control);
      done <= 1'b0;
    end else begin
      unique case (state)
        ADCSC_IDLE: begin
          // counter held quiet between sequences
          phase_count <= 6'h00;
        end
        ADCSC_SAMPLE: begin
          if (phase_count == 6'h01) begin
            state <= ADCSC_CONVERT;
            phase_count <= ADCSC_CONVERT_CYCLES;
          end else begin
            phase_count <= phase_count - 6'h01;
          end
        end
        ADCSC_CONVERT: begin
          if (phase_count != 6'h01) begin
            phase_count <= phase_count - 6'h01;
          end else begin
            // multi mode steps the channel after each conversion
            if (multi_channel_select) begin
              chan <= chan + 4'h1;
            end
            phase_count <= ADCSC_SAMPLE_CYCLES;
            if (next_conv_left != 5'h00) begin
              state <= ADCSC_SAMPLE;
              conv_left <= next_conv_left;
            end else if (continuous_select
                & ~external_trigger_enable) begin
              // restart from the coded channel
              state <= ADCSC_SAMPLE;
              conv_left <= seq_len(setup);
              chan <= chan_code(conversion_sequence_control);
            end else begin
              state <= ADCSC_IDLE;
              done <= 1'b1;
            end
          end
        end
        default: begin
          // unused code: fall back to idle
          state <= ADCSC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // converter outputs
  // decoded from the state flop: no added latency
  assign sample_enable = (state == ADCSC_SAMPLE);
  assign channel_select = chan;

  // formatting is combinational; result_data is the flop
  adcsc_format u_format (
    .raw(adc_data),
    .justify_right(result_justify_select),
    .signed_sel(signed_result_select),
    .result(formatted)
  );

  // pulse lines up with the first sampling cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      sequence_start <= 1'b0;
    end else begin
      sequence_start <= start_now;
    end
  end

  // an aborting write drops the result in flight
  always_ff @(posedge clk) begin
    if (reset) begin
      result_valid <= 1'b0;
      result_channel <= '0;
      result_data <= '0;
    end else begin
      result_valid <= 1'b0;
      if (state == ADCSC_CONVERT && phase_count == 6'h01
          && !control_write) begin
        result_valid <= 1'b1;
        result_channel <= chan;
        result_data <= formatted;
      end
    end
  end
endmodule

// *** src/adcsc_pkg.sv ***
package adcsc_pkg;
  // ==========================================================
  // register map (byte addresses, word aligned)
  localparam logic [3:0] ADCSC_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADCSC_ADDR_SETUP = 4'h4;
  localparam logic [3:0] ADCSC_ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADCSC_ADDR_RESULT = 4'hC;
  localparam int ADCSC_ADDR_W = 4;
  // ==========================================================
  // control register fields
  localparam int ADCSC_BIT_JUSTIFY = 7;
  localparam int ADCSC_BIT_SIGNED = 6;
  localparam int ADCSC_BIT_CONTINUOUS = 5;
  localparam int ADCSC_BIT_MULTI = 4;
  localparam int ADCSC_CODE_LSB = 0;
  localparam int ADCSC_CODE_W = 4;
  localparam logic [7:0] ADCSC_CONTROL_RESET = 8'h00;
  // ==========================================================
  // setup register fields
  localparam int ADCSC_BIT_TRIG_EN = 4;
  localparam int ADCSC_LEN_LSB = 0;
  localparam int ADCSC_LEN_W = 4;
  localparam logic [7:0] ADCSC_SETUP_RESET = 8'h00;
  // length code zero means a full sequence of sixteen
  localparam logic [4:0] ADCSC_LEN_FULL = 5'h10;
  // ==========================================================
  // status register fields
  localparam int ADCSC_BIT_BUSY = 0;
  localparam int ADCSC_BIT_ARMED = 1;
  localparam int ADCSC_BIT_DONE = 2;
  localparam int ADCSC_STAT_CHAN_LSB = 4;
  // ==========================================================
  // converter timing and widths
  localparam int ADCSC_RAW_W = 10;
  localparam int ADCSC_RES_W = 16;
  localparam logic [5:0] ADCSC_SAMPLE_CYCLES = 6'h04;
  localparam logic [5:0] ADCSC_CONVERT_CYCLES = 6'h0A;
  localparam logic [31:0] ADCSC_UNMAPPED_DATA = 32'h00000000;
  typedef enum logic [1:0] {
    ADCSC_IDLE, ADCSC_SAMPLE, ADCSC_CONVERT
  } adcsc_state_t;
endpackage

// *** src/adcsc_format.sv ***
module adcsc_format
  import adcsc_pkg::*;
(
  input wire logic [ADCSC_RAW_W-1:0] raw,
  input wire logic justify_right,
  input wire logic signed_sel,
  output logic [ADCSC_RES_W-1:0] result
);
  // ==========================================================
  // result placement
  always_comb begin
    if (justify_right) begin
      // signed form not offered here
      result = {6'h00, raw};
    end else if (signed_sel) begin
      // offset binary to two's complement: flip the msb
      result = {~raw[ADCSC_RAW_W-1], raw[ADCSC_RAW_W-2:0], 6'h00};
    end else begin
      result = {raw, 6'h00};
    end
  end
endmodule

// *** src/adcsc_sync.sv ***
module adcsc_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  // ==========================================================
  // two flop synchroniser for pin inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** sim/adcsc_checker.sv ***
module adcsc_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [adcsc_pkg::ADCSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic sample_enable,
  input wire logic sequence_start,
  input wire logic result_valid,
  input wire logic [adcsc_pkg::ADCSC_CODE_W-1:0] result_channel,
  input wire logic [adcsc_pkg::ADCSC_RES_W-1:0] result_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import adcsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // shadow copies, since the checker cannot see registers
  logic [7:0] ctl;
  logic [7:0] setup;
  wire taken = avs_write && !avs_waitrequest;
  wire ctl_wr = taken && avs_address == ADCSC_ADDR_CONTROL;
  wire setup_wr = taken && avs_address == ADCSC_ADDR_SETUP;
  always_ff @(posedge clk) begin
    if (reset) ctl <= 8'h00;
    else if (ctl_wr) ctl <= avs_writedata[7:0];
  end
  always_ff @(posedge clk) begin
    if (reset) setup <= 8'h00;
    else if (setup_wr) setup <= avs_writedata[7:0];
  end
  // ==========================================================
  // properties
  property p_restart;
    ctl_wr && !setup[ADCSC_BIT_TRIG_EN]
      |=> sample_enable[*4] ##1 !sample_enable;
  endproperty
  a_restart: assert property (p_restart)
    else $error("control write did not restart sampling");
  property p_arm;
    ctl_wr && setup[ADCSC_BIT_TRIG_EN] |=> !sample_enable[*3];
  endproperty
  a_arm: assert property (p_arm)
    else $error("trigger mode started without a trigger");
  property p_sample_len;
    $rose(sample_enable) |-> sample_enable[*4] ##1 !sample_enable;
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sampling phase length wrong");
  property p_start;
    sequence_start |-> ##[0:1] sample_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("start not followed by sampling");
  property p_left;
    result_valid && !ctl[ADCSC_BIT_JUSTIFY] |-> result_data[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left)
    else $error("left justified result has low bits set");
  property p_right;
    result_valid && ctl[ADCSC_BIT_JUSTIFY] |-> result_data[15:10] == 6'h00;
  endproperty
  a_right: assert property (p_right)
    else $error("right justified result not zero extended");
  property p_chan;
    result_valid && !ctl[ADCSC_BIT_MULTI] |-> result_channel == ctl[3:0];
  endproperty
  a_chan: assert property (p_chan)
    else $error("single channel result from wrong channel");
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus wait state count wrong");
endmodule
bind adcsc_top adcsc_checker adcsc_checker_i (.clk, .reset, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .sample_enable,
  .sequence_start, .result_valid, .result_channel, .result_data);

// *** sim/adcsc_analog_model.sv ***
module adcsc_analog_model (
  input wire logic clk,
  input wire logic [adcsc_pkg::ADCSC_CODE_W-1:0] channel_select,
  output logic [adcsc_pkg::ADCSC_RAW_W-1:0] adc_data,
  output logic external_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  import adcsc_pkg::*;
  // ==========================================================
  // each input carries its own level so a wrong channel shows
  assign adc_data = {channel_select, 6'h15};
  initial external_trigger = 1'b0;
  // held three cycles so the two-flop synchroniser cannot miss it
  task automatic fire;
    @(posedge clk);
    external_trigger <= 1'b1;
    repeat (3) @(posedge clk);
    external_trigger <= 1'b0;
  endtask
endmodule

// *** sim/tb_adcsc_top.sv ***
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
  end end
module tb_adcsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcsc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic external_trigger;
  logic [9:0] adc_data;
  logic sample_enable;
  logic [3:0] channel_select;
  logic sequence_start;
  logic result_valid;
  logic [3:0] result_channel;
  logic [15:0] result_data;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  adcsc_top adcsc_top_i (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .external_trigger,
    .adc_data, .sample_enable, .channel_select, .sequence_start,
    .result_valid, .result_channel, .result_data);
  adcsc_analog_model adcsc_analog_model_i (.clk, .channel_select, .adc_data,
    .external_trigger);
  // ==========================================================
  // helpers
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_res(input logic [3:0] ch, input logic [15:0] d);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (result_valid === 1'b1) break;
    end
    `CHK(result_valid, 1'b1)
    `CHK(result_channel, ch)
    `CHK(result_data, d)
  endtask
  task automatic no_res(input int n);
    int c;
    c = 0;
    repeat (n) @(posedge clk) if (result_valid !== 1'b0) c++;
    `CHK(c, 0)
  endtask
  function automatic logic [15:0] fmt(logic [3:0] ch, logic j, logic s);
    if (j) return {6'h00, ch, 6'h15};
    return {ch[3] ^ s, ch[2:0], 6'h15, 6'h00};
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    bus(0, ADCSC_ADDR_CONTROL, 0, d);
    `CHK(d[7:0], 8'h00)
    bus(0, ADCSC_ADDR_SETUP, 0, d);
    `CHK(d[7:0], 8'h00)
    bus(1, ADCSC_ADDR_SETUP, 32'h05, d);
    bus(0, ADCSC_ADDR_SETUP, 0, d);
    `CHK(d[7:0], 8'h05)
    bus(0, 4'h2, 0, d);
    `CHK(d, ADCSC_UNMAPPED_DATA)
    $display("regs done");
  endtask
  task automatic t_format;
    logic [31:0] d;
    bus(1, ADCSC_ADDR_SETUP, 32'h01, d);
    for (int m = 0; m < 4; m++) begin
      bus(1, ADCSC_ADDR_CONTROL, {24'h0, m[1:0], 6'h03}, d);
      wait_res(4'h3, fmt(4'h3, m[1], m[0]));
    end
    no_res(60);
    $display("format done");
  endtask
  task automatic t_multi;
    logic [31:0] d;
    bus(1, ADCSC_ADDR_SETUP, 32'h03, d);
    bus(1, ADCSC_ADDR_CONTROL, 32'h1E, d);
    for (int k = 0; k < 3; k++) begin
      wait_res(4'hE + k[3:0], fmt(4'hE + k[3:0], 0, 0));
    end
    no_res(60);
    $display("multi done");
  endtask
  task automatic t_abort;
    logic [31:0] d;
    bus(1, ADCSC_ADDR_SETUP, 32'h01, d);
    bus(1, ADCSC_ADDR_CONTROL, 32'h21, d);
    wait_res(4'h1, fmt(4'h1, 0, 0));
    repeat (8) @(posedge clk);
    bus(1, ADCSC_ADDR_CONTROL, 32'h05, d);
    wait_res(4'h5, fmt(4'h5, 0, 0));
    no_res(60);
    $display("abort done");
  endtask
  task automatic t_trig;
    logic [31:0] d;
    bus(1, ADCSC_ADDR_SETUP, 32'h11, d);
    bus(1, ADCSC_ADDR_CONTROL, 32'h27, d);
    no_res(40);
    adcsc_analog_model_i.fire();
    wait_res(4'h7, fmt(4'h7, 0, 0));
    no_res(60);
    adcsc_analog_model_i.fire();
    wait_res(4'h7, fmt(4'h7, 0, 0));
    bus(0, ADCSC_ADDR_STATUS, 0, d);
    `CHK(d, 32'h00000076)
    bus(0, ADCSC_ADDR_RESULT, 0, d);
    `CHK(d, {16'h0000, fmt(4'h7, 0, 0)})
    $display("trigger done");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_format();
    t_multi();
    t_abort();
    t_trig();
    report_and_stop();
  end
endmodule
